//--- verilog/cipd_irq_pd.sv
// Interrupt flags, line routing, local and chip power-down, wake-up and
// debug-suspend handshake of a 32-mailbox CAN controller.
// Assumes the protocol engine supplies event pulses and frame status, and
// that CPU write-1-to-clear strobes arrive as one-cycle masks.
`timescale 1ns/1ps
module cipd_irq_pd (
   input  wire logic                     clk,
   input  wire logic                     rst,
   input  wire cipd_pkg::cipd_mbvec_type mailboxLevel,
   input  wire cipd_pkg::cipd_mbvec_type mailboxMask,
   input  wire cipd_pkg::cipd_mbvec_type mailboxEnable,
   input  wire cipd_pkg::cipd_gmask_type globalMask,
   input  wire cipd_pkg::cipd_flag_type  flagClrLine0,
   input  wire cipd_pkg::cipd_flag_type  flagClrLine1,
   input  wire cipd_pkg::cipd_mbvec_type rxPendClr,
   input  wire cipd_pkg::cipd_mbvec_type txDoneClr,
   input  wire cipd_pkg::cipd_mbvec_type abortDoneClr,
   input  wire cipd_pkg::cipd_mbvec_type rxLostClr,
   input  wire cipd_pkg::cipd_mbvec_type rxEvent,
   input  wire cipd_pkg::cipd_mbvec_type txEvent,
   input  wire cipd_pkg::cipd_mbvec_type abortEvent,
   input  wire cipd_pkg::cipd_mbvec_type lostEvent,
   input  wire cipd_pkg::cipd_errev_type errEvent,
   input  wire logic                     busOffState,
   input  wire logic                     txInProgress,
   input  wire logic                     frameInProgress,
   input  wire logic                     bitTick,
   input  wire logic                     canReceivePin,
   input  wire logic                     pdrWrite,
   input  wire logic                     pdrData,
   input  wire logic                     busWakeEnable,
   input  wire logic                     ccrWrite,
   input  wire logic                     ccrData,
   input  wire logic                     globalPdReq,
   input  wire logic                     suspendReq,
   output logic                          irqLine0,
   output logic                          irqLine1,
   output cipd_pkg::cipd_flag_type       globalFlagLine0,
   output cipd_pkg::cipd_flag_type       globalFlagLine1,
   output cipd_pkg::cipd_mbvec_type      rxPendingBits,
   output cipd_pkg::cipd_mbvec_type      txDoneBits,
   output cipd_pkg::cipd_mbvec_type      abortDoneBits,
   output cipd_pkg::cipd_mbvec_type      rxLostFlags,
   output logic                          powerdownRequest,
   output logic                          powerdownActive,
   output logic                          baseClkEnable,
   output logic                          busActive,
   output logic                          rxDiscard,
   output logic                          cfgChangeRequest,
   output logic                          globalPdAck,
   output logic                          wakeIrqAsync,
   output logic                          suspendAck
);
   typedef struct packed {
      cipd_pkg::cipd_pd_type                  pd;
      logic                                   pdReq;
      logic                                   cfg_change_request;
      logic                                   busOffAtSleep;
      cipd_pkg::cipd_mbvec_type               rxPend;
      cipd_pkg::cipd_mbvec_type               txDone;
      cipd_pkg::cipd_mbvec_type               abortDone;
      cipd_pkg::cipd_mbvec_type               rxLost;
      logic [1:0][cipd_pkg::SYS_N-1:0]        sys;
      logic [1:0][cipd_pkg::FLAG_W-1:0]       flag;
      logic [1:0]                             irq;
      logic                                   gpdAck;
      logic                                   suspAck;
   } cipd_state_type;

   cipd_state_type s_reg;
   cipd_state_type s_next;
   logic           idleSeen;

   // Highest pending mailbox wins the vector
   function automatic logic [cipd_pkg::MIV_W-1:0] mbVector(
      input cipd_pkg::cipd_mbvec_type pend);
      logic [cipd_pkg::MIV_W-1:0] v;
      v = cipd_pkg::MIV_NONE;
      for (int i = 0; i < cipd_pkg::NMB; i++) begin
         if (pend[i]) begin
            v = i[cipd_pkg::MIV_W-1:0];
         end
      end
      return v;
   endfunction : mbVector

   cipd_idle_detect u_idle (
      .clk      (clk),
      .rst      (rst),
      .restart  (s_reg.pd != cipd_pkg::PD_WAKE),
      .bitTick  (bitTick),
      .rxPin    (canReceivePin),
      .idleSeen (idleSeen)
   );

   logic                          rxDominant;
   logic                          busWakeNow;
   logic                          wakeSet;
   cipd_pkg::cipd_mbvec_type      mbIrq;
   cipd_pkg::cipd_mbvec_type      lineMb;
   cipd_pkg::cipd_sysvec_type     sysSet;
   cipd_pkg::cipd_flag_type       clrMask;
   logic                          global_mailbox_flag;

   assign rxDominant = !canReceivePin;
   assign busWakeNow = (s_reg.pd == cipd_pkg::PD_SLEEP) && busWakeEnable && rxDominant;

   always_comb begin
      s_next = s_reg;
      lineMb = '0;
      clrMask = '0;
      global_mailbox_flag = 1'b0;
      // Chip power-down holds off until the frame being transmitted is over
      s_next.gpdAck = globalPdReq && (s_reg.gpdAck || !txInProgress);
      wakeSet = (globalPdReq && txInProgress)
         || (s_reg.gpdAck && rxDominant)
         || busWakeNow;
      wakeSet = wakeSet && globalMask.sysEnable[cipd_pkg::SYS_WAKE];

      // Set wins over a same-cycle clear on every sticky bit
      s_next.rxPend = (s_reg.rxPend & ~rxPendClr) | rxEvent | lostEvent;
      s_next.txDone = (s_reg.txDone & ~txDoneClr) | txEvent;
      s_next.abortDone = (s_reg.abortDone & ~abortDoneClr) | abortEvent;
      s_next.rxLost = (s_reg.rxLost & ~rxLostClr) | lostEvent;

      sysSet = '0;
      sysSet[cipd_pkg::SYS_WL] = errEvent.warnLevel;
      sysSet[cipd_pkg::SYS_EP] = errEvent.errPassive;
      sysSet[cipd_pkg::SYS_BO] = errEvent.busOff;
      sysSet[cipd_pkg::SYS_WD] = errEvent.writeDenied;
      sysSet[cipd_pkg::SYS_LOST] = |lostEvent;
      sysSet[cipd_pkg::SYS_AB] = |abortEvent;
      sysSet[cipd_pkg::SYS_WAKE] = wakeSet;

      mbIrq = (s_next.rxPend | s_next.txDone) & mailboxMask & mailboxEnable;

      for (int l = 0; l < 2; l++) begin
         lineMb = mbIrq & (l == 1 ? mailboxLevel : ~mailboxLevel);
         clrMask = (l == 1) ? flagClrLine1 : flagClrLine0;
         s_next.sys[l] = (s_reg.sys[l] & ~clrMask[cipd_pkg::SYS_LSB +: cipd_pkg::SYS_N])
            | ((globalMask.systemLineSelect == (l == 1)) ? sysSet : '0);
         global_mailbox_flag = |lineMb;
         s_next.flag[l] = {cipd_pkg::FLAG_HI, global_mailbox_flag, s_next.sys[l], cipd_pkg::FLAG_GAP,
            global_mailbox_flag ? mbVector(lineMb) : cipd_pkg::MIV_NONE};
         s_next.irq[l] = ((l == 1) ? globalMask.lineOneEnable : globalMask.lineZeroEnable)
            && (global_mailbox_flag || |(s_next.sys[l] & globalMask.sysEnable));
      end

      // Freeze only between frames; at least one clock of latency
      s_next.suspAck = suspendReq && (s_reg.suspAck || !frameInProgress);

      case (s_reg.pd)
         cipd_pkg::PD_RUN: begin
            // A frame being transmitted finishes before sleep, so no error frame
            if (s_reg.pdReq && !txInProgress) begin
               s_next.pd = cipd_pkg::PD_SLEEP;
               s_next.busOffAtSleep = busOffState;
            end
         end
         cipd_pkg::PD_SLEEP: begin
            if (!s_reg.pdReq) begin
               s_next.pd = cipd_pkg::PD_RUN;
            end else if (busWakeNow) begin
               s_next.pd = cipd_pkg::PD_WAKE;
               s_next.pdReq = 1'b0;
               if (s_reg.busOffAtSleep) begin
                  s_next.cfg_change_request = 1'b1;
               end
            end
         end
         cipd_pkg::PD_WAKE: begin
            if (idleSeen) begin
               s_next.pd = cipd_pkg::PD_RUN;
            end
         end
         default: begin
            s_next.pd = cipd_pkg::PD_RUN;
         end
      endcase

      // Software writes stay effective in every power state, except a ccrWrite in the same cycle as a bus wake after bus-off
      if (pdrWrite) begin
         s_next.pdReq = pdrData;
      end
      if (ccrWrite && !(busWakeNow && s_reg.busOffAtSleep)) begin
         s_next.cfg_change_request = ccrData;
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         s_reg <= '0;
         s_reg.pd <= cipd_pkg::PD_RUN;
         s_reg.cfg_change_request <= cipd_pkg::CCR_RESET;
      end else begin
         s_reg <= s_next;
      end
   end

   // Every output except wakeIrqAsync comes from state that runs on the free clock, so reads stay
   // correct while the base clock is stopped. No DMA request exists.
   assign irqLine0 = s_reg.irq[0];
   assign irqLine1 = s_reg.irq[1];
   assign globalFlagLine0 = s_reg.flag[0];
   assign globalFlagLine1 = s_reg.flag[1];
   assign rxPendingBits = s_reg.rxPend;
   assign txDoneBits = s_reg.txDone;
   assign abortDoneBits = s_reg.abortDone;
   assign rxLostFlags = s_reg.rxLost;
   assign powerdownRequest = s_reg.pdReq;
   assign powerdownActive = (s_reg.pd == cipd_pkg::PD_SLEEP);
   assign baseClkEnable = !powerdownActive;
   assign busActive = (s_reg.pd == cipd_pkg::PD_RUN) && !s_reg.suspAck;
   assign rxDiscard = (s_reg.pd != cipd_pkg::PD_RUN);
   assign cfgChangeRequest = s_reg.cfg_change_request;
   assign globalPdAck = s_reg.gpdAck;
   // Unfiltered path so a wake needs no running clock
   assign wakeIrqAsync = s_reg.gpdAck && rxDominant
      && globalMask.sysEnable[cipd_pkg::SYS_WAKE];
   assign suspendAck = s_reg.suspAck;

   // Either sticky source may back the vector, so check against their union
   cipd_pkg::cipd_mbvec_type pendAny;
   assign pendAny = rxPendingBits | txDoneBits;

   default clocking cb @(posedge clk); endclocking
   default disable iff (rst);

   sequence sSleepWithBusOff;
      s_reg.pd == cipd_pkg::PD_RUN && s_reg.pdReq && !txInProgress && busOffState;
   endsequence

   sequence sBusWake;
      s_reg.pd == cipd_pkg::PD_SLEEP && s_reg.pdReq && busWakeNow && !pdrWrite;
   endsequence

   a_line_enable: assert property (!globalMask.lineZeroEnable |=> !irqLine0)
      else $error("line 0 asserted while disabled");

   a_rxpend_setwins: assert property (rxEvent[0] && rxPendClr[0] |=> rxPendingBits[0])
      else $error("receive pending lost on clear collision");

   a_vector_valid: assert property (globalFlagLine0[cipd_pkg::GLOBAL_MAILBOX_FLAG_BIT] |->
      pendAny[globalFlagLine0[cipd_pkg::MIV_W-1:0]])
      else $error("vector names an idle mailbox");

   a_abort_flag: assert property (abortEvent[7] && !globalMask.systemLineSelect
      |=> globalFlagLine0[cipd_pkg::SYS_LSB + cipd_pkg::SYS_AB] && abortDoneBits[7])
      else $error("abort not flagged");

   a_lost_flag: assert property (lostEvent[5] && globalMask.systemLineSelect
      |=> globalFlagLine1[cipd_pkg::SYS_LSB + cipd_pkg::SYS_LOST]
      && rxLostFlags[5] && rxPendingBits[5])
      else $error("lost message not flagged");

   a_masked_quiet: assert property (mailboxMask == '0 && globalMask.sysEnable == '0
      |=> !irqLine0 && !irqLine1)
      else $error("masked sources raised a line");

   a_pd_hold: assert property (s_reg.pd == cipd_pkg::PD_RUN && txInProgress
      |=> !powerdownActive)
      else $error("sleep entered during transmission");

   a_pd_enter: assert property (s_reg.pd == cipd_pkg::PD_RUN && s_reg.pdReq && !txInProgress
      |=> powerdownActive && !baseClkEnable)
      else $error("sleep not entered");

   a_wake_clear: assert property (sBusWake |=> !powerdownRequest && !powerdownActive
      && rxDiscard && !busActive)
      else $error("wake did not clear power-down bits");

   a_busoff_ccr: assert property (sSleepWithBusOff ##1 sBusWake |=> cfgChangeRequest)
      else $error("configuration request not set on wake");

   a_bus_active: assert property ($rose(busActive) && $past(s_reg.pd == cipd_pkg::PD_WAKE)
      |-> $past(idleSeen))
      else $error("bus active before idle run");

   a_susp_ack: assert property (suspendReq && frameInProgress && !suspendAck
      |=> !suspendAck)
      else $error("suspend acknowledged mid-frame");
endmodule : cipd_irq_pd

//--- verilog/cipd_pkg.sv
// Constants and carrier types for the CAN interrupt and power-down block.
// Assumes one 25 MHz clock; the bit-timing logic supplies a sample-point tick.
package cipd_pkg;
   localparam int NMB      = 32;
   localparam int MIV_W    = 5;
   localparam int FLAG_W   = 32;
   localparam int SYS_N    = 7;
   // System flag indices, same order in flag words and enables
   localparam int SYS_WL   = 0;
   localparam int SYS_EP   = 1;
   localparam int SYS_BO   = 2;
   localparam int SYS_LOST = 3;
   localparam int SYS_WAKE = 4;
   localparam int SYS_WD   = 5;
   localparam int SYS_AB   = 6;
   // Flag word layout
   localparam int MIV_LSB  = 0;
   localparam int SYS_LSB  = 8;
   localparam int GLOBAL_MAILBOX_FLAG_BIT = 15;
   localparam logic [2:0] FLAG_GAP = 3'h0;
   localparam logic [15:0] FLAG_HI = 16'h0000;
   localparam logic [MIV_W-1:0] MIV_NONE = 5'h00;
   // Recessive run needed before going bus-active after a wake
   localparam logic [3:0] IDLE_BITS = 4'hb;
   localparam logic       CCR_RESET = 1'h1;

   typedef logic [NMB-1:0]    cipd_mbvec_type;
   typedef logic [SYS_N-1:0]  cipd_sysvec_type;
   typedef logic [FLAG_W-1:0] cipd_flag_type;

   typedef struct packed {
      logic            lineOneEnable;
      logic            lineZeroEnable;
      logic            systemLineSelect;
      cipd_sysvec_type sysEnable;
   } cipd_gmask_type;

   typedef struct packed {
      logic writeDenied;
      logic busOff;
      logic errPassive;
      logic warnLevel;
   } cipd_errev_type;

   typedef enum logic [1:0] {PD_RUN, PD_SLEEP, PD_WAKE} cipd_pd_type;
endpackage : cipd_pkg

//--- verilog/cipd_idle_detect.sv
// Counts consecutive recessive bit samples on the receive pin.
// Assumes bitTick pulses once per bit at the sample point.
`timescale 1ns/1ps
module cipd_idle_detect (
   input  wire logic clk,
   input  wire logic rst,
   input  wire logic restart,
   input  wire logic bitTick,
   input  wire logic rxPin,
   output logic      idleSeen
);
   typedef struct packed {
      logic [3:0] cnt;
      logic       seen;
   } cipd_idle_type;

   cipd_idle_type s_reg;
   cipd_idle_type s_next;

   always_comb begin
      s_next = s_reg;
      if (restart) begin
         s_next = '0;
      end else if (bitTick && !s_reg.seen) begin
         if (!rxPin) begin
            s_next.cnt = '0;
         end else if (s_reg.cnt == cipd_pkg::IDLE_BITS - 4'h1) begin
            s_next.seen = 1'b1;
         end else begin
            s_next.cnt = s_reg.cnt + 4'h1;
         end
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         s_reg <= '0;
      end else begin
         s_reg <= s_next;
      end
   end

   assign idleSeen = s_reg.seen;

   a_idle_count: assert property (@(posedge clk) disable iff (rst)
      $rose(s_reg.seen) |-> $past(bitTick) && $past(rxPin))
      else $error("idle seen without a recessive sample");
endmodule : cipd_idle_detect

//--- tb/cipd_can_bus_model.sv
// Model of the CAN bus seen through the receive pin, with the bit-rate tick.
// Assumes one shared clock; a frame starts on a one-cycle startFrame pulse.
`timescale 1ns/1ps
module cipd_can_bus_model #(
   parameter int BIT_CYC    = 4,
   parameter int FRAME_BITS = 20
) (
   input  wire logic clk,
   input  wire logic rst,
   input  wire logic startFrame,
   output logic      canPin,
   output logic      bitTick,
   output logic      frameBusy
);
   int cntReg;
   int bitIdxReg;
   always_ff @(posedge clk) begin
      if (rst) begin
         cntReg <= 0;
         bitIdxReg <= 0;
         canPin <= 1'b1;
         bitTick <= 1'b0;
         frameBusy <= 1'b0;
      end else begin
         bitTick <= (cntReg == BIT_CYC - 1);
         cntReg <= (cntReg == BIT_CYC - 1) ? 0 : cntReg + 1;
         if (startFrame && !frameBusy) begin
            frameBusy <= 1'b1;
            bitIdxReg <= 0;
         end else if (frameBusy && cntReg == BIT_CYC - 1) begin
            // Every third bit recessive, so no idle run inside a frame; idle bus is recessive
            canPin <= (bitIdxReg % 3 == 2) || (bitIdxReg == FRAME_BITS);
            bitIdxReg <= bitIdxReg + 1;
            if (bitIdxReg == FRAME_BITS) frameBusy <= 1'b0;
         end
      end
   end
endmodule : cipd_can_bus_model

//--- tb/cipd_irq_pd_tb_top.sv
// Self-checking bench for the interrupt and power-down block.
// Assumes the bus model in cipd_can_bus_model; expectations are queued and checked at negedge.
`timescale 1ns/1ps
module cipd_irq_pd_tb_top;
   typedef struct packed { logic [3:0] code; logic [31:0] val; } cipd_exp_type;
   logic clk = 1'b0;
   logic rst = 1'b1;
   cipd_pkg::cipd_mbvec_type mailboxLevel = '0, mailboxMask = '1, mailboxEnable = '1;
   cipd_pkg::cipd_gmask_type globalMask = 10'h37f;
   cipd_pkg::cipd_flag_type  flagClrLine0 = '0, flagClrLine1 = '0;
   cipd_pkg::cipd_mbvec_type rxPendClr = '0, txDoneClr = '0, abortDoneClr = '0, rxLostClr = '0;
   cipd_pkg::cipd_mbvec_type rxEvent = '0, txEvent = '0, abortEvent = '0, lostEvent = '0;
   cipd_pkg::cipd_errev_type errEvent = '0;
   logic busOffState = 0, txInProgress = 0, pdrWrite = 0, pdrData = 0, busWakeEnable = 0;
   logic ccrWrite = 0, ccrData = 0, globalPdReq = 0, suspendReq = 0, startFrame = 0;
   logic frameInProgress, bitTick, canReceivePin, irqLine0, irqLine1, powerdownRequest;
   logic powerdownActive, baseClkEnable, busActive, rxDiscard, cfgChangeRequest;
   logic globalPdAck, wakeIrqAsync, suspendAck;
   cipd_pkg::cipd_flag_type  globalFlagLine0, globalFlagLine1;
   cipd_pkg::cipd_mbvec_type rxPendingBits, txDoneBits, abortDoneBits, rxLostFlags;
   cipd_exp_type expQ[$];
   cipd_exp_type e;
   string nm[9] = '{"flag0", "flag1", "irq", "rxPend", "txDone", "abort", "lost", "pd", "misc"};
   int nFail = 0;
   int checked = 0;
   int cyc = 0;
   int a, b, hi, lo, ln, k, sel, i;
   logic [31:0] lvl;

   cipd_irq_pd u_dut (.clk, .rst, .mailboxLevel, .mailboxMask, .mailboxEnable, .globalMask,
      .flagClrLine0, .flagClrLine1, .rxPendClr, .txDoneClr, .abortDoneClr, .rxLostClr,
      .rxEvent, .txEvent, .abortEvent, .lostEvent, .errEvent, .busOffState, .txInProgress,
      .frameInProgress, .bitTick, .canReceivePin, .pdrWrite, .pdrData, .busWakeEnable,
      .ccrWrite, .ccrData, .globalPdReq, .suspendReq, .irqLine0, .irqLine1, .globalFlagLine0,
      .globalFlagLine1, .rxPendingBits, .txDoneBits, .abortDoneBits, .rxLostFlags,
      .powerdownRequest, .powerdownActive, .baseClkEnable, .busActive, .rxDiscard,
      .cfgChangeRequest, .globalPdAck, .wakeIrqAsync, .suspendAck);
   cipd_can_bus_model u_bus (.clk, .rst, .startFrame, .canPin(canReceivePin), .bitTick,
      .frameBusy(frameInProgress));

   always #20 clk = ~clk;

   function automatic logic [31:0] obs(input logic [3:0] c);
      case (c)
         0: obs = globalFlagLine0;
         1: obs = globalFlagLine1;
         2: obs = {30'h0, irqLine1, irqLine0};
         3: obs = rxPendingBits;
         4: obs = txDoneBits;
         5: obs = abortDoneBits;
         6: obs = rxLostFlags;
         7: obs = {26'h0, powerdownRequest, powerdownActive, baseClkEnable, busActive,
                   rxDiscard, cfgChangeRequest};
         default: obs = {29'h0, globalPdAck, wakeIrqAsync, suspendAck};
      endcase
   endfunction : obs
   function automatic logic [31:0] oh(input int n);
      oh = 32'h0000_0001 << n;
   endfunction : oh
   task automatic ex(input logic [3:0] code, input logic [31:0] val);
      expQ.push_back({code, val});
   endtask : ex
   // One edge, then every strobe and event input back to idle
   task automatic clr();
      @(posedge clk);
      {rxEvent, txEvent, abortEvent, lostEvent, errEvent} <= '0;
      {rxPendClr, txDoneClr, abortDoneClr, rxLostClr, flagClrLine0, flagClrLine1} <= '0;
      {pdrWrite, ccrWrite, startFrame} <= '0;
   endtask : clr
   task automatic wc(input int s, input logic [31:0] m);
      @(posedge clk);
      if (s == 1) flagClrLine1 <= m;
      else flagClrLine0 <= m;
      clr();
   endtask : wc
   task automatic pdw(input logic d);
      @(posedge clk);
      pdrWrite <= 1'b1;
      pdrData <= d;
      clr();
   endtask : pdw
   task automatic ccrw();
      @(posedge clk);
      ccrWrite <= 1'b1;
      ccrData <= 1'b0;
      clr();
   endtask : ccrw
   task automatic frame(input logic waitPin);
      @(posedge clk) startFrame <= 1'b1;
      clr();
      // Let the model's busy flag settle before polling it
      @(negedge clk);
      k = 0;
      while ((waitPin ? canReceivePin : frameInProgress) === 1'b1 && k < 400) begin
         @(negedge clk);
         k++;
      end
      @(posedge clk);
   endtask : frame
   task automatic stop_test();
      $display("checks %0d mismatches %0d", checked, nFail);
      if (nFail == 0 && checked > 0) $display("STATUS OK");
      else $display("STATUS NOT OK");
      $finish;
   endtask : stop_test

   always @(negedge clk) begin
      while (expQ.size() > 0) begin
         e = expQ.pop_front();
         checked++;
         if (obs(e.code) !== e.val) begin
            nFail++;
            $display("MISMATCH %s expected %h seen %h", nm[e.code], e.val, obs(e.code));
         end
      end
   end
   always @(posedge clk) begin
      cyc++;
      if (cyc == 20000) begin
         nFail++;
         stop_test();
      end
   end

   initial begin
      void'($urandom(95));
      repeat (4) @(posedge clk);
      rst <= 1'b0;
      ex(7, 32'h0000_000d); ex(2, 32'h0000_0000); ex(0, 32'h0000_0000); ex(8, 0);
      for (k = 0; k < 8; k++) begin
         a = $urandom % 32;
         b = (a + 1 + $urandom % 31) % 32;
         ln = $urandom % 2;
         hi = (a > b) ? a : b;
         lo = (a > b) ? b : a;
         lvl = $urandom;
         lvl[a] = ln[0];
         lvl[b] = ln[0];
         @(posedge clk) mailboxLevel <= lvl;
         @(posedge clk) begin
            rxEvent <= oh(a);
            txEvent <= oh(b);
         end
         clr();
         ex(ln, 32'h0000_8000 | hi); ex(!ln, 0); ex(2, oh(ln));
         ex(3, oh(a)); ex(4, oh(b));
         @(posedge clk) if (hi == a) rxPendClr <= oh(a); else txDoneClr <= oh(b);
         clr();
         ex(ln, 32'h0000_8000 | lo); ex(2, oh(ln));
         @(posedge clk) {rxPendClr, txDoneClr} <= {oh(a), oh(b)};
         clr();
         ex(ln, 0); ex(2, 0);
      end
      @(posedge clk) {mailboxLevel, mailboxMask, mailboxEnable} <= {32'h0, ~oh(3), ~oh(9)};
      @(posedge clk) rxEvent <= oh(3) | oh(9);
      clr();
      ex(0, 0); ex(2, 0);
      @(posedge clk) rxPendClr <= '1;
      clr();
      {mailboxMask, mailboxEnable} <= '1;
      globalMask.lineZeroEnable <= 1'b0;
      @(posedge clk) rxEvent <= oh(4);
      clr();
      ex(0, 32'h0000_8004); ex(2, 0);
      @(posedge clk) globalMask.lineZeroEnable <= 1'b1;
      clr();
      ex(2, 1);
      @(posedge clk) rxPendClr <= oh(4);
      clr();
      for (sel = 0; sel < 2; sel++) begin
         @(posedge clk) begin
            globalMask.systemLineSelect <= sel[0];
            mailboxLevel <= {32{~sel[0]}};
         end
         @(posedge clk) lostEvent <= oh(5);
         clr();
         ex(sel, 32'h0000_0800); ex(!sel, 32'h0000_8005); ex(2, 3); ex(6, oh(5));
         @(posedge clk) {rxPendClr, rxLostClr} <= {oh(5), oh(5)};
         clr();
         ex(sel, 32'h0000_0800); ex(!sel, 0);
         wc(sel, 32'h0000_0800);
         ex(sel, 0); ex(2, 0);
         @(posedge clk) globalMask.sysEnable[cipd_pkg::SYS_AB] <= !sel;
         @(posedge clk) abortEvent <= oh(7);
         clr();
         ex(sel, 32'h0000_4000); ex(5, oh(7)); ex(2, sel ? 0 : oh(sel));
         @(posedge clk) abortDoneClr <= oh(7);
         clr();
         ex(sel, 32'h0000_4000); ex(5, 0);
         wc(sel, 32'h0000_4000);
         for (i = 0; i < 4; i++) begin
            @(posedge clk) errEvent <= 4'h1 << i;
            clr();
            ex(sel, oh(8 + ((i == 3) ? 5 : i)));
            wc(sel, 32'h0000_7f00);
            ex(sel, 0);
         end
      end
      globalMask.sysEnable <= 7'h7f;
      ccrw();
      ex(7, 32'h0000_000c);
      {txInProgress, busOffState} <= 2'b11;
      pdw(1'b1);
      ex(7, 32'h0000_002c);
      repeat (5) @(posedge clk);
      ex(7, 32'h0000_002c);
      @(posedge clk) txInProgress <= 1'b0;
      repeat (3) @(posedge clk);
      ex(7, 32'h0000_0032);
      frame(1'b0);
      ex(7, 32'h0000_0032);
      pdw(1'b0);
      @(posedge clk);
      ex(7, 32'h0000_000c);
      busWakeEnable <= 1'b1;
      pdw(1'b1);
      repeat (2) @(posedge clk);
      busOffState <= 1'b0;
      frame(1'b1);
      ex(7, 32'h0000_000b); ex(1, 32'h0000_1000);
      frame(1'b0);
      repeat (40) @(posedge clk);
      ex(7, 32'h0000_000b);
      repeat (14) @(posedge clk);
      ex(7, 32'h0000_000d);
      wc(1, 32'h0000_1000);
      ccrw();
      globalMask.systemLineSelect <= 1'b0;
      {txInProgress, globalPdReq} <= 2'b11;
      repeat (3) @(posedge clk);
      ex(0, 32'h0000_1000); ex(8, 0);
      @(posedge clk) txInProgress <= 1'b0;
      clr();
      ex(8, 32'h0000_0004);
      frame(1'b1);
      ex(8, 32'h0000_0006);
      globalPdReq <= 1'b0;
      frame(1'b0);
      wc(0, 32'h0000_1000);
      ex(0, 0);
      frame(1'b1);
      suspendReq <= 1'b1;
      repeat (5) @(posedge clk);
      ex(8, 0);
      frame(1'b0);
      ex(8, 32'h0000_0001); ex(7, 32'h0000_0008);
      @(posedge clk) suspendReq <= 1'b0;
      clr();
      ex(8, 0);
      repeat (2) @(posedge clk);
      stop_test();
   end
endmodule : cipd_irq_pd_tb_top
